//--- core/cfs_pkg.sv
package cfs_pkg;

  // fan-out width and synchroniser depth
  localparam int unsigned CFS_NUM_OUT     = 9;
  localparam int unsigned CFS_SYNC_STAGES = 3;

  // field positions inside the control carrier
  localparam int unsigned CFS_CTRL_SEL_POS   = 0;
  localparam int unsigned CFS_CTRL_EN_POS    = 1;
  localparam int unsigned CFS_CTRL_DRIVE_POS = 2;
  localparam int unsigned CFS_CTRL_WIDTH     = 3;

  // gating state: run passes the clock, hold blanks it after a source swap
  typedef enum logic [0:0] {
    CFS_RUN  = 1'h0,
    CFS_HOLD = 1'h1
  } cfs_state_t;

  // static control pins, carried together
  typedef struct packed {
    logic driver_float_n;
    logic sync_enable;
    logic input_select;
  } cfs_ctrl_t;

  // register state of the selector and gate
  typedef struct packed {
    logic                   sel;
    cfs_state_t             state;
    logic                   en_cap;
    logic                   clk_prev;
    logic [CFS_NUM_OUT-1:0] q;
    logic [CFS_NUM_OUT-1:0] oe;
  } cfs_gate_t;

  // values after reset
  localparam logic                   CFS_RST_SEL      = 1'h0;
  localparam cfs_state_t             CFS_RST_STATE    = CFS_RUN;
  localparam logic                   CFS_RST_EN_CAP   = 1'h0;
  localparam logic                   CFS_RST_CLK_PREV = 1'h0;
  localparam logic [CFS_NUM_OUT-1:0] CFS_RST_Q        = 9'h000;
  localparam logic [CFS_NUM_OUT-1:0] CFS_RST_OE       = 9'h000;

endpackage

//--- core/cfs_sync.sv
`timescale 1ns/100ps

module cfs_sync #(
  parameter int unsigned WIDTH = 2
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // asynchronous levels in
  input  wire logic [WIDTH-1:0] async_in,
  // filtered levels out
  output logic      [WIDTH-1:0] level_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } cfs_sync_st_t;

  cfs_sync_st_t r_ff;
  cfs_sync_st_t nxt_r;

  always_comb begin
    nxt_r    = r_ff;
    nxt_r.s1 = async_in;
    nxt_r.s2 = r_ff.s1;
    nxt_r.s3 = r_ff.s2;
    // change accepted only once two later stages agree
    for (int i = 0; i < int'(WIDTH); i++) begin
      if (r_ff.s2[i] == r_ff.s3[i]) begin
        nxt_r.lvl[i] = r_ff.s2[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign level_out = r_ff.lvl;

  default clocking cb_sync @(posedge clock); endclocking
  default disable iff (!rst_b);

  AST_SYNC_AGREE: assert property (
    $changed(level_out) |-> $past(r_ff.s2 == r_ff.s3)
  ) else $error("synchroniser output moved without stage agreement");

endmodule

//--- core/cfs_top.sv
// Summary of operation
// - Select low routes clock_in_a, select high routes clock_in_b to the path.
// - All nine outputs carry identical copies of the one selected clock.
// - Enable high passes the clock; enable low holds every output low.
// - Enable is captured at each falling edge of the selected clock only.
// - Gating follows the clock so no glitch or runt pulse appears.
// - driver_float_n low releases all output drivers; high drives them.
// - clock_in_b is an alternative, test, source beside clock_in_a.
`timescale 1ns/100ps

module cfs_top (
  // clock and reset
  input  wire logic                                  clock,
  input  wire logic                                  rst_b,
  // clock sources, sampled as pins
  input  wire logic                                  clock_in_a,
  input  wire logic                                  clock_in_b,
  // static control pins
  input  wire cfs_pkg::cfs_ctrl_t                    ctrl_in,
  // fanned-out clock and driver enables
  output logic      [cfs_pkg::CFS_NUM_OUT-1:0]       clock_out,
  output logic      [cfs_pkg::CFS_NUM_OUT-1:0]       clock_out_oe
);

  logic [1:0]                          clk_s;
  logic [cfs_pkg::CFS_CTRL_WIDTH-1:0]  ctl_s;
  logic                                sel_s;
  logic                                en_s;
  logic                                drv_s;
  logic                                cur;
  logic                                new_src;
  logic                                fall;
  logic                                en_gate;
  logic                                swap;
  cfs_pkg::cfs_gate_t                  r_ff;
  cfs_pkg::cfs_gate_t                  nxt_r;

  // source clocks are oversampled; they are levels here, not clock nets
  // limitation: each source phase must last two system clocks or more,
  // and a pin change reaches the outputs five system clocks later
  cfs_sync #(
    .WIDTH (2)
  ) u_clk_sync (
    .clock     (clock),
    .rst_b     (rst_b),
    .async_in  ({clock_in_b, clock_in_a}),
    .level_out (clk_s)
  );

  cfs_sync #(
    .WIDTH (cfs_pkg::CFS_CTRL_WIDTH)
  ) u_ctl_sync (
    .clock     (clock),
    .rst_b     (rst_b),
    .async_in  (ctrl_in),
    .level_out (ctl_s)
  );

  assign sel_s = ctl_s[cfs_pkg::CFS_CTRL_SEL_POS];
  assign en_s  = ctl_s[cfs_pkg::CFS_CTRL_EN_POS];
  assign drv_s = ctl_s[cfs_pkg::CFS_CTRL_DRIVE_POS];

  always_comb begin
    nxt_r    = r_ff;
    cur      = r_ff.sel ? clk_s[1] : clk_s[0];
    new_src  = sel_s ? clk_s[1] : clk_s[0];
    fall     = r_ff.clk_prev & ~cur;
    en_gate  = fall ? en_s : r_ff.en_cap;
    swap     = fall & (sel_s != r_ff.sel);
    nxt_r.clk_prev = cur;
    if (fall) begin
      // new enable from this edge on
      nxt_r.en_cap = en_s;
    end
    // swap only while low; new source blanked until its own fall,
    // so its first high phase after the swap is never a runt
    if (swap) begin
      nxt_r.sel      = sel_s;
      nxt_r.clk_prev = new_src;
    end
    unique case (r_ff.state)
      cfs_pkg::CFS_RUN: begin
        if (swap) begin
          nxt_r.state = cfs_pkg::CFS_HOLD;
        end
      end
      cfs_pkg::CFS_HOLD: begin
        // a fall of the new source ends the blanking
        if (fall && !swap) begin
          nxt_r.state = cfs_pkg::CFS_RUN;
        end
      end
    endcase
    nxt_r.q  = {cfs_pkg::CFS_NUM_OUT{cur & en_gate & (r_ff.state == cfs_pkg::CFS_RUN)}};
    nxt_r.oe = {cfs_pkg::CFS_NUM_OUT{drv_s}};
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      r_ff.sel      <= cfs_pkg::CFS_RST_SEL;
      r_ff.state    <= cfs_pkg::CFS_RST_STATE;
      r_ff.en_cap   <= cfs_pkg::CFS_RST_EN_CAP;
      r_ff.clk_prev <= cfs_pkg::CFS_RST_CLK_PREV;
      r_ff.q        <= cfs_pkg::CFS_RST_Q;
      r_ff.oe       <= cfs_pkg::CFS_RST_OE;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // both outputs straight from flops, so loads never see decode hazards
  assign clock_out    = r_ff.q;
  assign clock_out_oe = r_ff.oe;

  default clocking cb_top @(posedge clock); endclocking
  default disable iff (!rst_b);

  AST_SRC_A: assert property (
    (!r_ff.sel && r_ff.state == cfs_pkg::CFS_RUN && r_ff.en_cap && !fall)
      |=> clock_out[0] == $past(clk_s[0])
  ) else $error("output does not follow source a");

  AST_SRC_B: assert property (
    (r_ff.sel && r_ff.state == cfs_pkg::CFS_RUN && r_ff.en_cap && !fall)
      |=> clock_out[0] == $past(clk_s[1])
  ) else $error("output does not follow source b");

  AST_FANOUT_EQUAL: assert property (
    clock_out == {cfs_pkg::CFS_NUM_OUT{clock_out[0]}}
  ) else $error("outputs disagree");

  AST_DISABLED_LOW: assert property (
    (!r_ff.en_cap && !fall) |=> clock_out == '0 ##1 (clock_out == '0 || $past(fall))
  ) else $error("output high while disabled");

  AST_CAPTURE_FALL: assert property (
    fall |=> r_ff.en_cap == $past(en_s)
  ) else $error("enable not captured at falling edge");

  AST_HOLD_BETWEEN: assert property (
    !fall |=> $stable(r_ff.en_cap)
  ) else $error("enable captured away from a falling edge");

  AST_NO_RUNT_RISE: assert property (
    $rose(clock_out[0]) |-> ($past(cur) && !$past(r_ff.clk_prev))
  ) else $error("output rose away from a source rising edge");

  AST_NO_RUNT_FALL: assert property (
    $fell(clock_out[0]) |-> !$past(cur)
  ) else $error("output fell while source was high");

  AST_FLOAT: assert property (
    drv_s ##1 drv_s |=> clock_out_oe == '1 ##1 (!drv_s || clock_out_oe == '1)
  ) else $error("drivers released while driving requested");

  AST_RESUME_FULL: assert property (
    (fall && en_s && !r_ff.en_cap) |=> clock_out == '0
  ) else $error("enable took effect inside a low phase");

  // taps cur, fall and swap are sampled like any register
  AST_FLOAT_OFF: assert property (
    !drv_s |=> clock_out_oe == '0
  ) else $error("drivers enabled while release requested");

  AST_OE_EQUAL: assert property (
    clock_out_oe == {cfs_pkg::CFS_NUM_OUT{clock_out_oe[0]}}
  ) else $error("driver enables disagree");

  AST_SEL_AT_FALL: assert property (
    !fall |=> $stable(r_ff.sel)
  ) else $error("source swapped away from a falling edge");

  AST_SEL_TAKEN: assert property (
    swap
      |=> (r_ff.sel == $past(sel_s) && r_ff.state == cfs_pkg::CFS_HOLD)
  ) else $error("requested source not taken at falling edge");

  AST_SWAP_BLANK: assert property (
    (r_ff.state == cfs_pkg::CFS_HOLD) |=> clock_out == '0
  ) else $error("output high while a source swap is pending");

  AST_HOLD_RELEASE: assert property (
    (r_ff.state == cfs_pkg::CFS_HOLD && fall && !swap)
      |=> r_ff.state == cfs_pkg::CFS_RUN
  ) else $error("blanking not ended by the new source falling");

  AST_OUT_NEEDS_RUN: assert property (
    clock_out[0] |-> $past(cur && r_ff.state == cfs_pkg::CFS_RUN)
  ) else $error("output high without a running high source");

  AST_OUT_NEEDS_EN: assert property (
    clock_out[0] |-> $past(en_gate)
  ) else $error("output high without a captured enable");

  COV_ENABLE_ON: cover property (
    (fall && en_s && !r_ff.en_cap) ##[1:200] $rose(clock_out[0])
  );

  COV_SWAP: cover property (
    (r_ff.state == cfs_pkg::CFS_HOLD) ##[1:200] $rose(clock_out[0])
  );

  COV_FLOAT: cover property (
    $fell(clock_out_oe[0])
  );

  COV_SRC_B_RUN: cover property (
    (r_ff.sel && r_ff.state == cfs_pkg::CFS_RUN) ##[1:100] $rose(clock_out[0])
  );

  COV_DISABLE: cover property (
    (fall && !en_s && r_ff.en_cap) ##1 !r_ff.en_cap
  );

endmodule

//--- bench/cfs_board_model.sv
`timescale 1ns/100ps

module cfs_board_model (
  // system clock
  input  wire logic                            clock,
  // source clocks
  output logic                                 clock_in_a,
  output logic                                 clock_in_b,
  // clock loads
  input  wire logic [cfs_pkg::CFS_NUM_OUT-1:0] clock_out,
  input  wire logic [cfs_pkg::CFS_NUM_OUT-1:0] clock_out_oe,
  output wire       [cfs_pkg::CFS_NUM_OUT-1:0] pin
);
  int unsigned cnt = 0;

  // two sources from one shared counter, 16 and 24 system clocks per period, slow against the system clock
  always @(posedge clock) begin
    #1;
    cnt++;
  end

  assign clock_in_a = (cnt % 16) < 8;
  assign clock_in_b = (cnt % 24) < 12;

  for (genvar i = 0; i < cfs_pkg::CFS_NUM_OUT; i++) begin : g_pin
    assign pin[i] = clock_out_oe[i] ? clock_out[i] : 1'bz;
  end
endmodule

//--- bench/tb_top.sv
`timescale 1ns/100ps

module tb_top;
  logic               clock = 1'b0;
  logic               rst_b = 1'b0;
  logic               clock_in_a;
  logic               clock_in_b;
  cfs_pkg::cfs_ctrl_t ctrl_in = 3'h6;
  logic [8:0]         clock_out;
  logic [8:0]         clock_out_oe;
  wire  [8:0]         pin;
  int                 errors = 0;
  int                 n_checks = 0;
  int                 run_len = 0;
  logic               prev_q = 1'b0;

  always #10 clock = ~clock;

  cfs_top dut_u (.clock(clock), .rst_b(rst_b), .clock_in_a(clock_in_a),
    .clock_in_b(clock_in_b), .ctrl_in(ctrl_in), .clock_out(clock_out),
    .clock_out_oe(clock_out_oe));
  cfs_board_model brd_u (.clock(clock), .clock_in_a(clock_in_a), .clock_in_b(clock_in_b),
    .clock_out(clock_out), .clock_out_oe(clock_out_oe), .pin(pin));

  task automatic chk9(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // glitch watch: every phase at least a source half period
  // sampled mid-cycle, where the registered outputs have settled
  always @(negedge clock) begin
    if (rst_b) begin
      chk9(clock_out, {9{clock_out[0]}});
      if (prev_q !== clock_out[0]) begin
        chk9(9'(run_len < 8), 9'h000);
        run_len = 1;
      end else begin
        run_len = run_len + 1;
      end
    end
    prev_q = clock_out[0];
  end

  task automatic pass_cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // rising edges of one output within 96 cycles
  task automatic count_rises(input logic [8:0] exp);
    logic [8:0] n;
    logic       last;
    n = 9'h0;
    last = clock_out[0];
    repeat (96) begin
      @(posedge clock);
      #1;
      if (clock_out[0] && !last) n++;
      last = clock_out[0];
    end
    chk9(n, exp);
  endtask

  task automatic t_select(input logic sel, input logic [8:0] rises);
    ctrl_in.input_select = sel;
    pass_cycles(60);
    count_rises(rises);
  endtask

  task automatic t_disable();
    ctrl_in.sync_enable = 1'b0;
    pass_cycles(40);
    repeat (48) begin
      pass_cycles(1);
      chk9(clock_out, 9'h000);
    end
    ctrl_in.sync_enable = 1'b1;
    pass_cycles(40);
    count_rises(9'h006);
  endtask

  task automatic t_float();
    ctrl_in.driver_float_n = 1'b0;
    pass_cycles(8);
    chk9(clock_out_oe, 9'h000);
    chk9(pin, {9{1'bz}});
    ctrl_in.driver_float_n = 1'b1;
    pass_cycles(8);
    chk9(clock_out_oe, 9'h1ff);
    chk9(pin, clock_out);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    pass_cycles(6);
    chk9(clock_out, 9'h000);
    chk9(clock_out_oe, 9'h000);
    rst_b = 1'b1;
    pass_cycles(20);
    chk9(clock_out_oe, 9'h1ff);
    t_select(1'b0, 9'h006);
    t_select(1'b1, 9'h004);
    t_select(1'b0, 9'h006);
    t_disable();
    t_float();
    summarize();
  end
endmodule
